// >>> tsmac_pkg.sv
// Shared constants and types for the temperature sensor mode and alarm control
package tsmac_pkg;
    localparam int TEMP_W     = 16;
    localparam int EXT_W      = 18;
    localparam int HYST_W     = 8;
    localparam int HYST_SHIFT = 7;
    localparam int STAT_W     = 8;
    localparam int MASK_W     = 4;
    localparam int SEL_W      = 3;
    localparam int CNT_W      = 24;

    // Alarm status bit positions
    localparam int ST_UPPER_STATE = 0;
    localparam int ST_UPPER_EVENT = 1;
    localparam int ST_LOWER_STATE = 2;
    localparam int ST_LOWER_EVENT = 3;
    localparam int ST_RATE_STATE  = 4;
    localparam int ST_RATE_EVENT  = 5;
    localparam int ST_DONE        = 6;
    localparam int ST_FAULT       = 7;

    // Alarm mask bit positions
    localparam int MSK_UPPER = 0;
    localparam int MSK_LOWER = 1;
    localparam int MSK_RATE  = 2;
    localparam int MSK_FAULT = 3;

    // Reset values
    localparam logic              MODE_RST    = 1'b0;
    localparam logic              ONESHOT_RST = 1'b0;
    localparam logic              INTCOMP_RST = 1'b0;
    localparam logic [STAT_W-1:0] STATUS_RST  = 8'h00;
    localparam logic [TEMP_W-1:0] RESULT_RST  = 16'h0000;
    localparam logic [MASK_W-1:0] MASK_RST    = 4'h0;

    // Timing
    localparam int CLK_MHZ         = 20;
    localparam int ACTIVE_TIME_US  = 1000;
    localparam int ACTIVE_CYC      = ACTIVE_TIME_US * CLK_MHZ;
    localparam int PERIOD_UNIT_US  = 2000;
    localparam int PERIOD_UNIT_CYC = PERIOD_UNIT_US * CLK_MHZ;

    // Command word layout and checksum
    localparam int              CMD_CRC_BIT = 14;
    localparam int              CMD_LEN_LSB = 10;
    localparam int              CMD_RW_BIT  = 8;
    localparam logic [3:0]      LEN_MAX     = 4'ha;
    localparam logic [3:0]      LAST_BIT    = 4'hf;
    localparam logic [15:0]     CRC_POLY    = 16'h1021;
    localparam logic [15:0]     CRC_INIT    = 16'hffff;

    typedef enum logic [1:0] {
        CONV_SHUTDOWN = 2'b00,
        CONV_ACTIVE   = 2'b01,
        CONV_STANDBY  = 2'b10
    } tsmac_conv_t;
endpackage

// >>> tsmac_ctrl.sv
// Conversion sequencing, alarm logic and link checksum of the temperature sensor
//
// Overview of operation
// - Checksummed valid-length read appends 16-bit checksum
// - Checksummed write mismatch drops write, sets fault
// - Continuous mode updates result at conversion end
// - Done flag set per conversion, cleared by reads
// - Done flag mirrored on alarm pin when enabled
// - Fixed active time, period from 3-bit select
// - Mode 1 aborts conversion, enters shutdown
// - Mode change leaves alarm status untouched
// - Shutdown by mode write never raises rise-rate alarm anew
// - One-shot converts, then sets mode, enters shutdown
// - Retrigger during conversion restarts it
// - Pin behaviour change clears status and pin
// - Above upper threshold sets state, event, pin
// - Interrupt mode: status read clears events, pin
// - Upper hysteresis governs release and second event
// - Masked events still flag, never drive pin
// - Lower and rise-rate limits handled alike
// - Comparator pin follows enabled state bits
// - Comparator: disabling a limit mask bit drops pin at once
// - Mask changes apply after conversion or read
// - Status read clears fault and its alarm
`timescale 1ns/1ns
module tsmac_ctrl #(
    parameter int              ACTIVE_CYC      = tsmac_pkg::ACTIVE_CYC,
    parameter int              PERIOD_UNIT_CYC = tsmac_pkg::PERIOD_UNIT_CYC,
    parameter logic [15:0]     CRC_POLY        = tsmac_pkg::CRC_POLY,
    parameter logic [15:0]     CRC_INIT        = tsmac_pkg::CRC_INIT
) (
    input  wire logic                               clk,                    // Core clock
    input  wire logic                               srst,                   // Sync reset
    input  wire logic                               cfg_wr,                 // Config write pulse
    input  wire logic                               cfg_mode_wdata,         // Mode bit written
    input  wire logic                               cfg_oneshot_wdata,      // Trigger written
    input  wire logic                               pin_behaviour_select,   // 1 comparator
    input  wire logic                               done_to_pin_enable,     // Done on pin
    input  wire logic [tsmac_pkg::SEL_W-1:0]        sample_interval_sel,    // Period select
    input  wire logic [tsmac_pkg::MASK_W-1:0]       alarm_mask_reg,         // Pin enables
    input  wire logic [tsmac_pkg::TEMP_W-1:0]       upper_threshold,        // Signed limit
    input  wire logic [tsmac_pkg::TEMP_W-1:0]       lower_threshold,        // Signed limit
    input  wire logic [tsmac_pkg::TEMP_W-1:0]       rate_limit,             // Unsigned rise
    input  wire logic [tsmac_pkg::HYST_W-1:0]       upper_hysteresis,       // Upper band
    input  wire logic [tsmac_pkg::HYST_W-1:0]       lower_hysteresis,       // Lower band
    input  wire logic [tsmac_pkg::TEMP_W-1:0]       adc_sample,             // Converter value
    input  wire logic                               status_rd,              // Status read pulse
    input  wire logic                               result_rd,              // Result read pulse
    output logic                                    mode_bit,               // 1 shutdown
    output logic                                    single_conversion_trigger, // Trigger bit
    output logic                                    conversion_active,      // Converting
    output logic [tsmac_pkg::STAT_W-1:0]            alarm_status_reg,       // Status bits
    output logic [tsmac_pkg::TEMP_W-1:0]            temperature_result_reg, // Last result
    output logic                                    alarm_output_pin,       // Alarm, high
    input  wire logic                               spi_sclk,               // Link clock
    input  wire logic                               spi_cs_n,               // Frame select
    input  wire logic                               sio_in,                 // Data from wire
    input  wire logic                               link_tx_bit,            // Read data bit
    output logic                                    sio_out,                // Checksum bit
    output logic                                    sio_oe,                 // Drive enable
    output logic                                    link_write_discard      // Drop this write
);
    localparam int CW = tsmac_pkg::CNT_W;
    localparam int XW = tsmac_pkg::EXT_W;

    typedef struct packed {
        tsmac_pkg::tsmac_conv_t             cs;
        logic [CW-1:0]                      cnt;
        logic                               mode;
        logic                               oneshot;
        logic                               intcomp;
        logic [tsmac_pkg::STAT_W-1:0]       status;
        logic [tsmac_pkg::TEMP_W-1:0]       result;
        logic [tsmac_pkg::TEMP_W-1:0]       prev;
        logic                               prev_valid;
        logic [tsmac_pkg::MASK_W-1:0]       mask_eff;
        logic                               pin;
        logic [2:0]                         fsync;
    } tsmac_core_t;

    typedef struct packed {
        logic [3:0]                         bitcnt;
        logic [3:0]                         word;
        logic [15:0]                        sh;
        logic [15:0]                        crc;
        logic                               crc_en;
        logic [3:0]                         len;
        logic                               rw;
        logic                               mism;
        logic                               discard;
    } tsmac_link_t;

    tsmac_core_t          q;
    tsmac_core_t          nxt_q;
    tsmac_link_t          lq;
    tsmac_link_t          nxt_lq;
    logic                 fault_tgl_ff;
    logic                 link_flip;
    logic                 crc_phase;
    logic                 wire_bit;
    logic                 conv_done;
    logic                 start;
    logic                 fault_evt;
    logic                 mode_flip;
    logic                 rate_ok;
    logic signed [XW-1:0] res_x;
    logic signed [XW-1:0] rise_x;
    logic [1:0]           up_r;
    logic [1:0]           lo_r;
    logic [1:0]           rt_r;
    logic [2:0]           evs;
    logic [2:0]           sts;

    function automatic logic signed [XW-1:0] sx(input logic [15:0] v);
        sx = signed'({{(XW-16){v[15]}}, v});
    endfunction

    function automatic logic signed [XW-1:0] hx(input logic [7:0] h);
        hx = signed'(XW'({h, 7'h00}));
    endfunction

    // Returns {new state, event}
    function automatic logic [1:0] lim_eval(input logic st, input logic trig, input logic rel);
        if (!st && trig) begin
            lim_eval = 2'b11;
        end else if (st && rel) begin
            lim_eval = 2'b01;
        end else begin
            lim_eval = {st, 1'b0};
        end
    endfunction

    function automatic logic [CW-1:0] period_cyc(input logic [2:0] sel);
        period_cyc = CW'(PERIOD_UNIT_CYC) << sel;
    endfunction

    // ---------------- Core domain ----------------
    always_comb begin
        nxt_q     = q;
        conv_done = 1'b0;
        start     = 1'b0;
        mode_flip = 1'b0;
        nxt_q.fsync = {q.fsync[1:0], fault_tgl_ff};
        fault_evt = q.fsync[1] ^ q.fsync[2];
        if (cfg_wr) begin
            nxt_q.mode = cfg_mode_wdata;
            if (cfg_oneshot_wdata) begin
                nxt_q.oneshot = 1'b1;
                start = 1'b1;
            end else begin
                nxt_q.oneshot = 1'b0;
            end
        end
        case (q.cs)
            tsmac_pkg::CONV_SHUTDOWN: begin
                if (start || !nxt_q.mode) begin
                    nxt_q.cs  = tsmac_pkg::CONV_ACTIVE;
                    nxt_q.cnt = '0;
                end
            end
            tsmac_pkg::CONV_ACTIVE: begin
                if (start) begin
                    nxt_q.cnt = '0;
                end else if (nxt_q.mode && !nxt_q.oneshot) begin
                    nxt_q.cs = tsmac_pkg::CONV_SHUTDOWN;
                    nxt_q.prev_valid = 1'b0;
                end else if (q.cnt == CW'(ACTIVE_CYC - 1)) begin
                    conv_done = 1'b1;
                    if (q.oneshot) begin
                        nxt_q.mode    = 1'b1;
                        nxt_q.oneshot = 1'b0;
                        nxt_q.cs      = tsmac_pkg::CONV_SHUTDOWN;
                    end else begin
                        nxt_q.cs  = tsmac_pkg::CONV_STANDBY;
                        nxt_q.cnt = q.cnt + 1'b1;
                    end
                end else begin
                    nxt_q.cnt = q.cnt + 1'b1;
                end
            end
            default: begin
                if (start) begin
                    nxt_q.cs  = tsmac_pkg::CONV_ACTIVE;
                    nxt_q.cnt = '0;
                end else if (nxt_q.mode) begin
                    nxt_q.cs = tsmac_pkg::CONV_SHUTDOWN;
                    nxt_q.prev_valid = 1'b0;
                end else if (q.cnt >= period_cyc(sample_interval_sel) - 1'b1) begin
                    nxt_q.cs  = tsmac_pkg::CONV_ACTIVE;
                    nxt_q.cnt = '0;
                end else begin
                    nxt_q.cnt = q.cnt + 1'b1;
                end
            end
        endcase

        // Limit evaluation on the finished sample
        res_x  = sx(adc_sample);
        rise_x = res_x - sx(q.prev);
        up_r = lim_eval(q.status[tsmac_pkg::ST_UPPER_STATE],
                        res_x > sx(upper_threshold),
                        res_x < sx(upper_threshold) - hx(upper_hysteresis));
        lo_r = lim_eval(q.status[tsmac_pkg::ST_LOWER_STATE],
                        res_x < sx(lower_threshold),
                        res_x > sx(lower_threshold) + hx(lower_hysteresis));
        rt_r = lim_eval(q.status[tsmac_pkg::ST_RATE_STATE],
                        rise_x > signed'(XW'(rate_limit)),
                        rise_x <= signed'(XW'(rate_limit)));
        // Rise rate needs a fixed interval, so only continuous samples count, and only with prev_valid set
        rate_ok = q.prev_valid && !q.oneshot;

        // Clears first, so a set in the same cycle wins
        if (status_rd) begin
            nxt_q.status[tsmac_pkg::ST_UPPER_EVENT] = 1'b0;
            nxt_q.status[tsmac_pkg::ST_LOWER_EVENT] = 1'b0;
            nxt_q.status[tsmac_pkg::ST_RATE_EVENT]  = 1'b0;
            nxt_q.status[tsmac_pkg::ST_FAULT]       = 1'b0;
        end
        if (status_rd || result_rd) begin
            nxt_q.status[tsmac_pkg::ST_DONE] = 1'b0;
            nxt_q.mask_eff = alarm_mask_reg;
        end
        if (fault_evt) begin
            nxt_q.status[tsmac_pkg::ST_FAULT] = 1'b1;
        end

        if (pin_behaviour_select != q.intcomp) begin
            // New alarm behaviour starts from a clean slate
            mode_flip      = 1'b1;
            nxt_q.intcomp  = pin_behaviour_select;
            nxt_q.status   = tsmac_pkg::STATUS_RST;
        end else if (conv_done) begin
            nxt_q.result     = adc_sample;
            nxt_q.prev       = adc_sample;
            nxt_q.prev_valid = 1'b1;
            nxt_q.mask_eff   = alarm_mask_reg;
            nxt_q.status[tsmac_pkg::ST_DONE] = 1'b1;
            nxt_q.status[tsmac_pkg::ST_UPPER_STATE] = up_r[1];
            nxt_q.status[tsmac_pkg::ST_LOWER_STATE] = lo_r[1];
            if (up_r[0]) begin
                nxt_q.status[tsmac_pkg::ST_UPPER_EVENT] = 1'b1;
            end
            if (lo_r[0]) begin
                nxt_q.status[tsmac_pkg::ST_LOWER_EVENT] = 1'b1;
            end
            if (rate_ok) begin
                nxt_q.status[tsmac_pkg::ST_RATE_STATE] = rt_r[1];
                if (rt_r[0]) begin
                    nxt_q.status[tsmac_pkg::ST_RATE_EVENT] = 1'b1;
                end
            end
        end

        evs = {nxt_q.status[tsmac_pkg::ST_RATE_EVENT], nxt_q.status[tsmac_pkg::ST_LOWER_EVENT],
               nxt_q.status[tsmac_pkg::ST_UPPER_EVENT]};
        sts = {nxt_q.status[tsmac_pkg::ST_RATE_STATE], nxt_q.status[tsmac_pkg::ST_LOWER_STATE],
               nxt_q.status[tsmac_pkg::ST_UPPER_STATE]};
        // Pin behaviour changes clear status, so the pin is forced low as well
        if (mode_flip) begin
            nxt_q.pin = 1'b0;
        end else if (nxt_q.intcomp) begin
            // Live mask only removes, so disabling takes effect at once
            nxt_q.pin = |(sts & nxt_q.mask_eff[2:0] & alarm_mask_reg[2:0]);
        end else begin
            nxt_q.pin = |(evs & nxt_q.mask_eff[2:0]);
        end
        if (!mode_flip) begin
            nxt_q.pin = nxt_q.pin
                | (nxt_q.status[tsmac_pkg::ST_FAULT] & nxt_q.mask_eff[tsmac_pkg::MSK_FAULT])
                | (nxt_q.status[tsmac_pkg::ST_DONE] & done_to_pin_enable);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q          <= '0;
            q.mode     <= tsmac_pkg::MODE_RST;
            q.oneshot  <= tsmac_pkg::ONESHOT_RST;
            q.intcomp  <= tsmac_pkg::INTCOMP_RST;
            q.status   <= tsmac_pkg::STATUS_RST;
            q.result   <= tsmac_pkg::RESULT_RST;
            q.mask_eff <= tsmac_pkg::MASK_RST;
        end else begin
            q <= nxt_q;
        end
    end

    assign mode_bit                  = q.mode;
    assign single_conversion_trigger = q.oneshot;
    assign conversion_active         = (q.cs == tsmac_pkg::CONV_ACTIVE);
    assign alarm_status_reg          = q.status;
    assign temperature_result_reg    = q.result;
    assign alarm_output_pin          = q.pin;

    // ---------------- Link domain ----------------
    always_comb begin
        nxt_lq    = lq;
        link_flip = 1'b0;
        crc_phase = lq.crc_en && (lq.word == lq.len + 4'h1);
        if (lq.word != 4'h0 && lq.rw) begin
            wire_bit = crc_phase ? lq.crc[15] : link_tx_bit;
        end else begin
            wire_bit = sio_in;
        end
        // Checksum runs over every bit on the wire; while sent it simply shifts out
        nxt_lq.crc    = {lq.crc[14:0], 1'b0} ^ ((lq.crc[15] ^ wire_bit) ? CRC_POLY : 16'h0000);
        nxt_lq.sh     = {lq.sh[14:0], sio_in};
        nxt_lq.bitcnt = lq.bitcnt + 4'h1;
        if (crc_phase && !lq.rw && (sio_in != lq.crc[15])) begin
            nxt_lq.mism = 1'b1;
        end
        if (lq.bitcnt == tsmac_pkg::LAST_BIT) begin
            if (lq.word == 4'h0) begin
                nxt_lq.len    = nxt_lq.sh[tsmac_pkg::CMD_LEN_LSB +: 4];
                nxt_lq.rw     = nxt_lq.sh[tsmac_pkg::CMD_RW_BIT];
                nxt_lq.crc_en = nxt_lq.sh[tsmac_pkg::CMD_CRC_BIT]
                                && (nxt_lq.len != 4'h0)
                                && (nxt_lq.len <= tsmac_pkg::LEN_MAX);
            end
            if (lq.word != 4'hf) begin
                nxt_lq.word = lq.word + 4'h1;
            end
            if (crc_phase && !lq.rw && nxt_lq.mism) begin
                nxt_lq.discard = 1'b1;
                link_flip      = 1'b1;
            end
        end
    end

    // Frame select clears the link state, since the link clock stops between frames
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            lq     <= '0;
            lq.crc <= CRC_INIT;
        end else begin
            lq <= nxt_lq;
        end
    end

    // Toggle must survive frame end; only the core reset clears it
    always_ff @(posedge spi_sclk or posedge srst) begin
        if (srst) begin
            fault_tgl_ff <= 1'b0;
        end else if (link_flip) begin
            fault_tgl_ff <= ~fault_tgl_ff;
        end
    end

    assign sio_oe             = !spi_cs_n && crc_phase && lq.rw;
    assign sio_out            = lq.crc[15];
    assign link_write_discard = lq.discard;

    // ---------------- Checks ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_oneshot_end;
        conv_done && q.oneshot && !start && (pin_behaviour_select == q.intcomp);
    endsequence

    sequence s_shutdown_entered;
        q.mode && !q.oneshot && (q.cs == tsmac_pkg::CONV_SHUTDOWN)
            && q.status[tsmac_pkg::ST_DONE];
    endsequence

    a_oneshot_finish: assert property (s_oneshot_end |=> s_shutdown_entered)
        else $error("one-shot end did not enter shutdown");
    a_result_update: assert property (conv_done && (pin_behaviour_select == q.intcomp)
        |=> temperature_result_reg == $past(adc_sample))
        else $error("result not taken at conversion end");
    a_done_pin_follow: assert property (conv_done && done_to_pin_enable
        && (pin_behaviour_select == q.intcomp) |=> alarm_output_pin)
        else $error("done flag not on alarm pin");
    a_shutdown_abort: assert property (cfg_wr && cfg_mode_wdata && !cfg_oneshot_wdata
        |=> (q.cs == tsmac_pkg::CONV_SHUTDOWN) && !conversion_active)
        else $error("shutdown did not abort conversion");
    a_retrigger_restart: assert property (start |=> conversion_active && q.cnt == '0
        ##1 !conv_done)
        else $error("retrigger did not restart conversion");
    a_behaviour_clear: assert property (pin_behaviour_select != q.intcomp
        |=> alarm_status_reg == 8'h00 && !alarm_output_pin)
        else $error("behaviour change left status or pin");
    a_int_read_clear: assert property (!q.intcomp && !pin_behaviour_select && status_rd
        && !conv_done && !fault_evt && !done_to_pin_enable
        |=> !alarm_output_pin && alarm_status_reg[5] == 1'b0)
        else $error("status read did not clear interrupt");
    a_upper_crossing: assert property (conv_done && (pin_behaviour_select == q.intcomp)
        && !q.status[tsmac_pkg::ST_UPPER_STATE] && sx(adc_sample) > sx(upper_threshold)
        |=> alarm_status_reg[1:0] == 2'b11)
        else $error("upper crossing not flagged");
    a_fault_capture: assert property ($changed(fault_tgl_ff) |-> ##[2:4]
        alarm_status_reg[tsmac_pkg::ST_FAULT])
        else $error("checksum fault not flagged");
    a_mode_keeps_status: assert property (cfg_wr && !cfg_oneshot_wdata && !conv_done
        && !status_rd && (pin_behaviour_select == q.intcomp)
        |=> alarm_status_reg[5:0] == $past(alarm_status_reg[5:0]))
        else $error("mode write disturbed status");
endmodule

// >>> tsmac_spi_host.sv
// Behavioural host controller on the 3-wire serial link
`timescale 1ns/1ns
module tsmac_spi_host (
    output logic spi_sclk, // Link clock
    output logic spi_cs_n, // Frame select
    output wire  sio_in,   // Resolved data line
    input  logic sio_out,  // Device data bit
    input  logic sio_oe    // Device drives line
);
    logic hd;
    assign sio_in = sio_oe ? sio_out : hd;
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        hd = 1'b0;
    end
    // Clock stands still outside frames; line flips on release so stale data never reads true
    // The one caller sends a checksummed write with a zero checksum word, forcing a mismatch
    task automatic frame(input logic [47:0] b);
        spi_cs_n = 1'b0;
        #100;
        for (int i = 47; i >= 0; i--) begin
            hd = b[i];
            #62 spi_sclk = 1'b1;
            #63 spi_sclk = 1'b0;
        end
        #20 spi_cs_n = 1'b1;
        hd = ~hd;
    endtask
endmodule

// >>> temp_sensor_mode_alert_ctrl_tb_top.sv
// Self-checking bench for the sensor mode and alarm control
`timescale 1ns/1ns
module temp_sensor_mode_alert_ctrl_tb_top;
    logic        clk = 1'b0, srst = 1'b1, cfg_wr = 1'b0, md = 1'b0, os = 1'b0, sel = 1'b0;
    logic        srd = 1'b0, rrd = 1'b0, mb, trig, act, pin, sclk, csn, sin, sout, soe;
    logic [15:0] adc = 16'h0c80, res;
    logic [7:0]  st;
    logic        dpe = 1'b0;
    logic [3:0]  msk = 4'hf;
    logic [15:0] uth = 16'h3e80, lth = 16'he480, rlim = 16'hffff;
    logic [7:0]  hyu = 8'h00, hyl = 8'h00;
    int          num_errors = 0, total_checks = 0, cyc = 0;
    tsmac_spi_host host (.spi_sclk(sclk), .spi_cs_n(csn), .sio_in(sin), .sio_out(sout),
        .sio_oe(soe));
    tsmac_ctrl #(.ACTIVE_CYC(20), .PERIOD_UNIT_CYC(40)) uut (.clk(clk), .srst(srst),
        .cfg_wr(cfg_wr), .cfg_mode_wdata(md), .cfg_oneshot_wdata(os),
        .pin_behaviour_select(sel), .done_to_pin_enable(dpe), .sample_interval_sel(3'h0),
        .alarm_mask_reg(msk), .upper_threshold(uth), .lower_threshold(lth),
        .rate_limit(rlim), .upper_hysteresis(hyu), .lower_hysteresis(hyl),
        .adc_sample(adc), .status_rd(srd), .result_rd(rrd), .mode_bit(mb),
        .single_conversion_trigger(trig), .conversion_active(act), .alarm_status_reg(st),
        .temperature_result_reg(res), .alarm_output_pin(pin), .spi_sclk(sclk),
        .spi_cs_n(csn), .sio_in(sin), .link_tx_bit(1'b0), .sio_out(sout), .sio_oe(soe),
        .link_write_discard());
    initial forever #25 clk = ~clk;
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic m, input logic o);
        @(negedge clk) {cfg_wr, md, os} = {1'b1, m, o};
        @(negedge clk) cfg_wr = 1'b0;
    endtask
    task automatic rd_status();
        @(negedge clk) srd = 1'b1;
        @(negedge clk) srd = 1'b0;
    endtask
    task automatic t_cont();
        dpe = 1'b1;
        tick(30);
        chk("result", 16'h0c80, res);
        chk("done", 1, st[6]);
        chk("pin", 1, pin);
        @(negedge clk) rrd = 1'b1;
        @(negedge clk) rrd = 1'b0;
        chk("done", 0, st[6]);
        chk("pin", 0, pin);
        dpe = 1'b0;
    endtask
    task automatic t_shut();
        wr(1'b1, 1'b0);
        tick(2);
        chk("active", 0, act);
        chk("mode", 1, mb);
    endtask
    task automatic t_oneshot();
        adc = 16'h4b00;
        wr(1'b1, 1'b1);
        for (int i = 0; i < 40 && trig !== 1'b0; i++) tick(1);
        tick(1);
        chk("mode", 1, mb);
        chk("result", 16'h4b00, res);
        chk("status", 8'h43, st);
        chk("pin", 1, pin);
        rd_status();
        chk("status", 8'h01, st);
        chk("pin", 0, pin);
        sel = 1'b1;
        tick(2);
        chk("status", 8'h00, st);
    endtask
    task automatic t_crc();
        host.frame({16'h4403, 16'h1234, 16'h0000});
        tick(10);
        chk("fault", 1, st[7]);
        chk("pin", 1, pin);
        rd_status();
        chk("fault", 0, st[7]);
        chk("pin", 0, pin);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Run should end near 200 cycles; far above that means a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        tick(6);
        srst = 1'b0;
        t_cont();
        t_shut();
        t_oneshot();
        t_crc();
        print_verdict();
    end
endmodule
